/* File: adcsm_pkg.sv */
// Shared constants and types for the converter setup-mode control block
package adcsm_pkg;

    // ------------------------------------------------------------
    // Setup register layout and reset value
    // ------------------------------------------------------------
    localparam int         SETUP_W     = 8;
    localparam logic [7:0] SETUP_RESET = 8'h01;
    localparam int         MODE_MSB    = 7;
    localparam int         MODE_LSB    = 6;
    localparam int         GAIN_MSB    = 5;
    localparam int         GAIN_LSB    = 3;
    localparam int         POL_BIT     = 2;
    localparam int         BUF_BIT     = 1;
    localparam int         FILTER_SYNC_HOLD_BIT   = 0;

    localparam logic [1:0] MODE_NORMAL   = 2'h0;
    localparam logic [1:0] MODE_SELF     = 2'h1;
    localparam logic [1:0] MODE_SYS_ZERO = 2'h2;
    localparam logic [1:0] MODE_SYS_FULL = 2'h3;

    // ------------------------------------------------------------
    // Communication register layout and register selection
    // ------------------------------------------------------------
    localparam int         COMM_RS_MSB = 6;
    localparam int         COMM_RS_LSB = 4;
    localparam int         COMM_RW_BIT = 3;
    localparam int         COMM_CH_MSB = 1;
    localparam int         COMM_CH_LSB = 0;
    localparam logic [2:0] RS_COMM     = 3'h0;
    localparam logic [2:0] RS_SETUP    = 3'h1;
    localparam logic [1:0] CH_SHORTED  = 2'h2;
    localparam logic [1:0] PAIR_SHORT  = 2'h0;

    // ------------------------------------------------------------
    // Crossing word, timing counts and resets
    // ------------------------------------------------------------
    localparam int         HOLD_W         = 9;
    localparam int         HOLD_DATA_READY_FLAG      = 8;
    localparam logic [2:0] BIT_LAST       = 3'h7;
    localparam logic [1:0] SETTLE_PERIODS = 2'h3;
    localparam logic       DATA_READY_FLAG_RESET     = 1'b1;
    localparam logic       EV_COMM        = 1'b0;
    localparam logic       EV_SETUP       = 1'b1;

    typedef enum logic [2:0] {
        CAL_IDLE,
        CAL_SELF_ZERO,
        CAL_SELF_FULL,
        CAL_SYS_ZERO,
        CAL_SYS_FULL,
        CAL_WAIT_WORD
    } adcsm_cal_t;

    typedef enum logic [1:0] {
        PH_COMM,
        PH_WR,
        PH_RD
    } adcsm_phase_t;

endpackage : adcsm_pkg

/* File: adcsm_serial_link.sv */
// Serial-clock side: byte framing, register select and crossing events
`timescale 1ns/10ps
`default_nettype none
module adcsm_serial_link (
    // Link clock and reset
    input  wire logic                        i_sclk,
    input  wire logic                        i_arst_n,
    // Serial pins
    input  wire logic                        i_din,
    output logic                             o_dout,
    // Crossing to and from the master clock
    input  wire logic [adcsm_pkg::HOLD_W-1:0] i_hold,
    output logic                             o_busy,
    output logic                             o_ev_tgl,
    output logic                             o_ev_kind,
    output logic [7:0]                       o_ev_byte
);
    import adcsm_pkg::*;

    typedef struct packed {
        adcsm_phase_t phase;
        logic [2:0]   cnt;
        logic [7:0]   sh;
        logic         busy;
        logic         tgl;
        logic         kind;
        logic [7:0]   ev_byte;
        logic         dout;
    } adcsm_link_t;

    localparam adcsm_link_t LINK_RESET = '{phase: PH_COMM, default: '0};

    adcsm_link_t st;
    adcsm_link_t nx;
    logic [7:0]  byte_v;
    logic [7:0]  rd_v;
    logic [2:0]  rs_v;

    // ------------------------------------------------------------
    // Framing
    // ------------------------------------------------------------
    always_comb begin
        nx     = st;
        byte_v = {st.sh[6:0], i_din};
        rs_v   = byte_v[COMM_RS_MSB:COMM_RS_LSB];
        rd_v   = i_hold[7:0];
        if (rs_v == RS_COMM) begin
            rd_v = {i_hold[HOLD_DATA_READY_FLAG], byte_v[6:0]};
        end
        unique case (st.phase)
            PH_COMM: begin
                // A leading one is ignored: the frame waits for its zero
                if (st.cnt != 3'h0 || !i_din) begin
                    nx.busy = 1'b1;
                    nx.sh   = byte_v;
                    nx.cnt  = st.cnt + 3'h1;
                    if (st.cnt == BIT_LAST) begin
                        nx.busy    = 1'b0;
                        nx.tgl     = ~st.tgl;
                        nx.kind    = EV_COMM;
                        nx.ev_byte = byte_v;
                        if (!byte_v[COMM_RW_BIT] && rs_v == RS_SETUP) begin // [R14]
                            nx.phase = PH_WR;
                            nx.busy  = 1'b1;
                        end else if (byte_v[COMM_RW_BIT]
                                     && (rs_v == RS_SETUP || rs_v == RS_COMM)) begin
                            nx.phase = PH_RD;
                            nx.busy  = 1'b1;
                            nx.dout  = rd_v[7];
                            nx.sh    = {rd_v[6:0], 1'b0};
                        end
                    end
                end
            end
            PH_WR: begin
                nx.sh  = byte_v;
                nx.cnt = st.cnt + 3'h1;
                if (st.cnt == BIT_LAST) begin
                    nx.phase   = PH_COMM;
                    nx.busy    = 1'b0;
                    nx.tgl     = ~st.tgl;
                    nx.kind    = EV_SETUP;
                    nx.ev_byte = byte_v;
                end
            end
            PH_RD: begin
                nx.dout = st.sh[7];
                nx.sh   = {st.sh[6:0], 1'b0};
                nx.cnt  = st.cnt + 3'h1;
                if (st.cnt == BIT_LAST) begin
                    nx.phase = PH_COMM;
                    nx.busy  = 1'b0;
                    nx.dout  = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge i_sclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st <= LINK_RESET;
        end else begin
            st <= nx;
        end
    end

    assign o_dout    = st.dout;
    assign o_busy    = st.busy;
    assign o_ev_tgl  = st.tgl;
    assign o_ev_kind = st.kind;
    assign o_ev_byte = st.ev_byte;

endmodule : adcsm_serial_link
`default_nettype wire

/* File: adcsm_setup_ctrl.sv */
// Setup register, calibration sequencing and data-ready control
// Function
// R01: Mode field picks normal, self, zero-scale system or full-scale system calibration.
// R02: Self calibration runs zero-scale on shorted inputs, then full-scale on reference.
// R03: Finished calibration clears both mode bits back to normal by itself.
// R04: Writing a calibration mode code raises the data-ready pin and status bit.
// R05: Data-ready falls only after calibration ends and a fresh word is loaded.
// R06: Zero-scale system calibration uses the external input on the selected channel.
// R07: Full-scale system calibration uses the external input on the selected channel.
// R08: Polarity bit zero selects bipolar coding, one selects unipolar.
// R09: Buffer bit zero bypasses the input buffer, one puts it in series.
// R10: Filter-sync high holds filter, calibration control and modulator in reset.
// R11: After filter-sync falls, first valid word follows three output-rate periods.
// R12: Filter-sync leaves the serial side alone and never raises a low data-ready.
// R13: Gain equals two to the power of the three-bit gain code.
// R14: Register-select code 0,0,1 reaches the setup register.
// R15: Setup register is eight bits, mode-gain-polarity-buffer-sync, resetting to 01 hex.
// R16: Channel select picks the calibrated channel and its coefficient pair.
// R17: After calibration, normal conversion resumes with unchanged channel and settings.
`timescale 1ns/10ps
`default_nettype none
module adcsm_setup_ctrl (
    // Master clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_arst_n,
    // Serial link
    input  wire logic       i_sclk,
    input  wire logic       i_din,
    output logic            o_dout,
    // Filter and calibration datapath events
    input  wire logic       i_out_tick,
    input  wire logic       i_cal_step_done,
    input  wire logic       i_word_loaded,
    input  wire logic       i_word_read,
    // Data-ready pin, high while no fresh word
    output logic            o_data_ready_flag_n,
    // Setup fields and settled status
    output logic [1:0]      o_mode,
    output logic [2:0]      o_gain_code,
    output logic [7:0]      o_gain,
    output logic            o_unipolar,
    output logic            o_buffer_en,
    output logic            o_filter_reset,
    output logic            o_settled,
    // Channel and calibration steering
    output logic [1:0]      o_channel,
    output logic [1:0]      o_cal_pair,
    output logic            o_cal_zero,
    output logic            o_cal_full,
    output logic            o_cal_internal
);
    import adcsm_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] gain_of(input logic [2:0] code);
        gain_of = 8'h01 << code;
    endfunction : gain_of

    function automatic logic [1:0] pair_of(input logic [1:0] ch);
        // The shorted-input channel shares coefficients with channel 0
        pair_of = (ch == CH_SHORTED) ? PAIR_SHORT : ch;
    endfunction : pair_of

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic               tgl_s1;
        logic               tgl_s2;
        logic               tgl_s3;
        logic               busy_s1;
        logic               busy_s2;
        logic [SETUP_W-1:0] setup;
        logic [1:0]         chan;
        logic               data_ready_flag_n;
        adcsm_cal_t         cal;
        logic [1:0]         settle;
        logic               settle_done;
        logic [HOLD_W-1:0]  hold;
        logic [7:0]         gain;
        logic [1:0]         pair;
        logic               cal_zero;
        logic               cal_full;
        logic               cal_internal;
    } adcsm_ctrl_t;

    localparam adcsm_ctrl_t CTRL_RESET = '{
        setup:   SETUP_RESET,
        data_ready_flag_n:  DATA_READY_FLAG_RESET,
        cal:     CAL_IDLE,
        hold:    {DATA_READY_FLAG_RESET, SETUP_RESET},
        gain:    gain_of(SETUP_RESET[GAIN_MSB:GAIN_LSB]),
        default: '0
    };

    adcsm_ctrl_t st;
    adcsm_ctrl_t nx;

    logic       link_busy;
    logic       ev_tgl;
    logic       ev_kind;
    logic [7:0] ev_byte;
    logic       ev;
    logic       comm_wr;
    logic       setup_wr;
    logic       cal_wr;
    logic       nx_filter_sync_hold;
    logic       settled;
    logic [1:0] cur_mode;

    // ------------------------------------------------------------
    // Serial side on the link clock
    // ------------------------------------------------------------
    adcsm_serial_link u_link (
        .i_sclk    (i_sclk),
        .i_arst_n  (i_arst_n),
        .i_din     (i_din),
        .o_dout    (o_dout),
        .i_hold    (st.hold),
        .o_busy    (link_busy),
        .o_ev_tgl  (ev_tgl),
        .o_ev_kind (ev_kind),
        .o_ev_byte (ev_byte)
    );

    // Event data changes on the same link edge as the toggle and then stays stable
    // for a whole byte time, so it is read directly once the toggle has crossed
    assign ev       = st.tgl_s2 ^ st.tgl_s3;
    assign comm_wr  = ev && (ev_kind == EV_COMM);
    assign setup_wr = ev && (ev_kind == EV_SETUP);
    assign cal_wr   = setup_wr && (ev_byte[MODE_MSB:MODE_LSB] != MODE_NORMAL);
    assign settled  = st.settle_done;
    assign cur_mode = st.setup[MODE_MSB:MODE_LSB];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nx         = st;
        nx.tgl_s1  = ev_tgl;
        nx.tgl_s2  = st.tgl_s1;
        nx.tgl_s3  = st.tgl_s2;
        nx.busy_s1 = link_busy;
        nx.busy_s2 = st.busy_s1;

        // Read-back word only moves while no frame is in flight
        if (!st.busy_s2) begin
            nx.hold = {st.data_ready_flag_n, st.setup};
        end

        if (comm_wr) begin
            nx.chan = ev_byte[COMM_CH_MSB:COMM_CH_LSB];           // [R16]
        end
        if (setup_wr) begin
            nx.setup = ev_byte;                                   // [R14] [R15]
        end
        nx_filter_sync_hold = nx.setup[FILTER_SYNC_HOLD_BIT];

        // Filter settling after sync release
        if (nx_filter_sync_hold) begin
            nx.settle = 2'h0;                                     // [R10]
        end else if (i_out_tick && !settled) begin
            nx.settle = st.settle + 2'h1;                         // [R11]
        end
        // Kept in a flop so the settled output needs no decode after the register
        nx.settle_done = (nx.settle == SETTLE_PERIODS);           // [R11]

        // Reading the word makes the pin go inactive again
        if (i_word_read) begin
            nx.data_ready_flag_n = 1'b1;
        end

        // Calibration control is parked while the filter is held
        if (nx_filter_sync_hold) begin
            nx.cal = CAL_IDLE;                                    // [R10] [R12]
        end else begin
            unique case (st.cal)
                CAL_IDLE: begin
                    unique case (cur_mode)                        // [R01]
                        MODE_NORMAL: begin
                            if (i_word_loaded && settled) begin
                                nx.data_ready_flag_n = 1'b0;                 // [R11]
                            end
                        end
                        MODE_SELF: begin
                            nx.cal = CAL_SELF_ZERO;               // [R02]
                        end
                        MODE_SYS_ZERO: begin
                            nx.cal = CAL_SYS_ZERO;                // [R06]
                        end
                        MODE_SYS_FULL: begin
                            nx.cal = CAL_SYS_FULL;                // [R07]
                        end
                    endcase
                end
                CAL_SELF_ZERO: begin
                    if (i_cal_step_done) begin
                        nx.cal = CAL_SELF_FULL;                   // [R02]
                    end
                end
                CAL_SELF_FULL, CAL_SYS_ZERO, CAL_SYS_FULL: begin
                    if (i_cal_step_done) begin
                        nx.cal = CAL_WAIT_WORD;
                        // A host write landing now keeps its own mode
                        if (!setup_wr) begin
                            nx.setup[MODE_MSB:MODE_LSB] = MODE_NORMAL; // [R03] [R17]
                        end
                    end
                end
                CAL_WAIT_WORD: begin
                    // A calibration code written meanwhile restarts the sequence
                    if (cur_mode != MODE_NORMAL) begin
                        nx.cal = CAL_IDLE;                        // [R04]
                    end else if (i_word_loaded && settled) begin
                        nx.cal    = CAL_IDLE;
                        nx.data_ready_flag_n = 1'b0;                         // [R05]
                    end
                end
            endcase
        end

        // Starting a calibration wins over any fall this cycle
        if (cal_wr) begin
            nx.data_ready_flag_n = 1'b1;                                     // [R04]
        end

        // Registered steering outputs
        nx.gain         = gain_of(nx.setup[GAIN_MSB:GAIN_LSB]);   // [R13]
        nx.pair         = pair_of(nx.chan);                       // [R16]
        nx.cal_zero     = (nx.cal == CAL_SELF_ZERO) || (nx.cal == CAL_SYS_ZERO);
        nx.cal_full     = (nx.cal == CAL_SELF_FULL) || (nx.cal == CAL_SYS_FULL);
        nx.cal_internal = (nx.cal == CAL_SELF_ZERO) || (nx.cal == CAL_SELF_FULL);
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st <= CTRL_RESET;                                     // [R15]
        end else begin
            st <= nx;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_data_ready_flag_n = st.data_ready_flag_n;
    assign o_mode              = st.setup[MODE_MSB:MODE_LSB];
    assign o_gain_code         = st.setup[GAIN_MSB:GAIN_LSB];
    assign o_gain              = st.gain;
    assign o_unipolar          = st.setup[POL_BIT];               // [R08]
    assign o_buffer_en         = st.setup[BUF_BIT];               // [R09]
    assign o_filter_reset      = st.setup[FILTER_SYNC_HOLD_BIT];             // [R10]
    assign o_settled           = settled;
    assign o_channel           = st.chan;
    assign o_cal_pair          = st.pair;
    assign o_cal_zero          = st.cal_zero;
    assign o_cal_full          = st.cal_full;
    assign o_cal_internal      = st.cal_internal;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_arst_n);

    a_self_start: assert property (   // [R01]
        st.cal == CAL_IDLE && cur_mode == MODE_SELF && !nx_filter_sync_hold
        |=> st.cal == CAL_SELF_ZERO && o_cal_internal && o_cal_zero)
        else $error("self calibration did not start");

    a_self_order: assert property (   // [R02]
        st.cal == CAL_SELF_ZERO && i_cal_step_done && !nx_filter_sync_hold
        |=> o_cal_full && o_cal_internal && !o_cal_zero)
        else $error("self calibration skipped its full-scale step");

    a_mode_return: assert property (   // [R03]
        st.cal inside {CAL_SELF_FULL, CAL_SYS_ZERO, CAL_SYS_FULL}
        && i_cal_step_done && !ev && !nx_filter_sync_hold
        |=> o_mode == MODE_NORMAL && $stable(o_gain_code) && $stable(o_channel))
        else $error("mode bits not returned to normal");

    a_cal_data_ready_flag: assert property (   // [R04]
        cal_wr |=> o_data_ready_flag_n ##1 o_data_ready_flag_n)
        else $error("data-ready not raised by calibration write");

    a_data_ready_flag_wait: assert property (   // [R05]
        $fell(o_data_ready_flag_n)
        |-> $past(i_word_loaded) && $past(st.cal) inside {CAL_IDLE, CAL_WAIT_WORD}
            && $past(cur_mode) == MODE_NORMAL)
        else $error("data-ready fell without a fresh word");

    a_sys_steps: assert property (   // [R06]
        st.cal == CAL_IDLE && cur_mode[MODE_MSB-MODE_LSB] && !nx_filter_sync_hold
        |=> !o_cal_internal && (o_cal_zero != o_cal_full))
        else $error("system calibration used internal inputs");

    a_sync_hold: assert property (   // [R10]
        o_filter_reset |-> st.cal == CAL_IDLE && st.settle == 2'h0 && !o_settled)
        else $error("filter-sync did not hold calibration and filter");

    a_settle_three: assert property (   // [R11]
        $fell(o_data_ready_flag_n) |-> $past(st.settle) == SETTLE_PERIODS)
        else $error("word delivered before filter settled");

    a_sync_no_rise: assert property (   // [R12]
        $rose(o_data_ready_flag_n) |-> $past(i_word_read) || $past(cal_wr))
        else $error("data-ready rose without read or calibration");

    a_gain_map: assert property (   // [R13]
        $changed(o_gain_code) |-> o_gain == (8'h01 << o_gain_code) && $onehot(o_gain))
        else $error("gain does not follow gain code");

    a_setup_load: assert property (   // [R08]
        setup_wr |=> o_unipolar == $past(ev_byte[POL_BIT])
                     && o_buffer_en == $past(ev_byte[BUF_BIT]))
        else $error("polarity or buffer bit not loaded");

    a_pair_map: assert property (   // [R16]
        comm_wr |=> o_channel == $past(ev_byte[COMM_CH_MSB:COMM_CH_LSB])
                    && o_cal_pair == pair_of(o_channel))
        else $error("channel or coefficient pair wrong");

    c_self_done: cover property (
        st.cal == CAL_SELF_FULL && i_cal_step_done ##[1:300] $fell(o_data_ready_flag_n));
    c_sys_full: cover property (st.cal == CAL_SYS_FULL && i_cal_step_done);
    c_sync_release: cover property ($fell(o_filter_reset) ##[1:300] o_settled);
    c_write_pair: cover property (comm_wr ##[1:300] setup_wr);

endmodule : adcsm_setup_ctrl
`default_nettype wire

/* File: adcsm_host_model.sv */
// Host serial master model; link clock runs only inside frames
`timescale 1ns/10ps
`default_nettype none
module adcsm_host_model (
    // Serial pins
    output logic      o_sclk,
    output logic      o_din,
    input  wire logic i_dout
);
    initial begin
        o_sclk = 1'b1;
        o_din  = 1'b0;
    end

    // One byte, MSB first; din moves while clock is low, dout is taken before each rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        #7.3;
        for (int i = 7; i >= 0; i--) begin
            o_sclk = 1'b0;
            o_din  = tx[i];
            #80;
            rx     = {rx[6:0], i_dout};
            o_sclk = 1'b1;
            #80;
        end
        // Released data line must not keep looking valid
        o_din = ~o_din;
    endtask : xfer
endmodule : adcsm_host_model
`default_nettype wire

/* File: test_adcsm_setup_ctrl.sv */
// Self-checking bench for setup register, calibration and data-ready control
`timescale 1ns/10ps
`default_nettype none
module test_adcsm_setup_ctrl;
    import adcsm_pkg::*;
    logic       i_mclk, i_arst_n, sclk, din, dout, data_ready_flag_n, fres, settled;
    logic       cz, cf, ci, unip, bufen;
    logic [3:0] ev;
    logic [1:0] mode, chan, pair;
    logic [2:0] gcode;
    logic [7:0] gain, rx;
    int         err_total, cmp_count;
    logic [7:0] row_in [8] = '{8'h01, 8'h0A, 8'h14, 8'h1F, 8'h23, 8'h2C, 8'h36, 8'h38};
    logic [7:0] row_gain [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};

    adcsm_setup_ctrl u_adcsm_setup_ctrl (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_sclk(sclk),
        .i_din(din), .o_dout(dout), .i_out_tick(ev[0]), .i_cal_step_done(ev[1]),
        .i_word_loaded(ev[2]), .i_word_read(ev[3]), .o_data_ready_flag_n(data_ready_flag_n),
        .o_mode(mode), .o_gain_code(gcode), .o_gain(gain), .o_unipolar(unip),
        .o_buffer_en(bufen), .o_filter_reset(fres), .o_settled(settled), .o_channel(chan),
        .o_cal_pair(pair), .o_cal_zero(cz), .o_cal_full(cf), .o_cal_internal(ci));
    adcsm_host_model u_adcsm_host_model (.o_sclk(sclk), .o_din(din), .i_dout(dout));

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
    endtask : cyc

    // Event bits: 0 tick, 1 step done, 2 word loaded, 3 word read
    task automatic pulse(input int k);
        @(posedge i_mclk);
        ev <= 4'(1 << k);
        @(posedge i_mclk);
        ev <= 4'h0;
        cyc(2);
    endtask : pulse

    // Comm byte then data byte; crossing settles within 4 master edges
    task automatic wr(input logic [7:0] comm, input logic [7:0] data);
        u_adcsm_host_model.xfer(comm, rx);
        u_adcsm_host_model.xfer(data, rx);
        cyc(6);
    endtask : wr

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    initial begin
        #500000;
        err_total++;
        stop_test();
    end

    initial begin
        i_arst_n  = 1'b0;
        ev        = 4'h0;
        err_total = 0;
        cmp_count = 0;
        cyc(12);
        i_arst_n <= 1'b1;
        cyc(2);
        chk({mode, gcode, unip, bufen, fres}, SETUP_RESET);
        chk({gain[6:0], data_ready_flag_n}, 8'h03);
        wr(8'h18, 8'h00);
        chk(rx, SETUP_RESET);
        for (int r = 0; r < 8; r++) begin
            wr(8'h10, row_in[r]);
            chk({mode, gcode, unip, bufen, fres}, row_in[r]);
            chk(gain, row_gain[r]);
            wr(8'h18, 8'h00);
            chk(rx, row_in[r]);
        end
        // Unused select consumes only the comm byte
        u_adcsm_host_model.xfer(8'h50, rx);
        wr(8'h18, 8'h00);
        chk(rx, 8'h38);
        pulse(0);
        pulse(0);
        pulse(2);
        chk({settled, data_ready_flag_n}, 8'h01);
        pulse(0);
        pulse(2);
        chk({settled, data_ready_flag_n}, 8'h02);
        wr(8'h12, 8'h7C);
        chk({mode, cz, cf, ci, data_ready_flag_n}, 8'h1B);
        chk({chan, pair}, 8'h08);
        pulse(2);
        chk({7'h0, data_ready_flag_n}, 8'h01);
        pulse(1);
        chk({mode, cz, cf, ci}, 8'h0B);
        pulse(1);
        chk({mode, cz, cf, ci, data_ready_flag_n}, 8'h01);
        chk({chan, gcode, unip, bufen}, 8'h5E);
        pulse(2);
        chk({7'h0, data_ready_flag_n}, 8'h00);
        wr(8'h10, 8'h01);
        chk({fres, settled, data_ready_flag_n}, 8'h04);
        wr(8'h08, 8'h00);
        chk(rx, 8'h08);
        for (int m = 2; m < 4; m++) begin
            wr(8'h11, {2'(m), 6'h00});
            chk({mode, cz, cf, ci, data_ready_flag_n}, {2'h0, 2'(m), (m == 2) ? 4'h9 : 4'h5});
            chk({chan, pair}, 8'h05);
            pulse(1);
            chk({6'h0, mode}, 8'h00);
            pulse(0);
            pulse(0);
            pulse(0);
            pulse(2);
            chk({7'h0, data_ready_flag_n}, 8'h00);
        end
        pulse(3);
        chk({7'h0, data_ready_flag_n}, 8'h01);
        stop_test();
    end
endmodule : test_adcsm_setup_ctrl
`default_nettype wire
